// ---- adccr_top.v ----
// Converter clock select and result format registers behind an APB slave
`timescale 1ns/1ps
`include "adccr_defs.vh"
// Bus timing: a setup cycle is answered in the following access cycle,
// so every transfer takes exactly one wait-free access cycle.
// Register map: format word, clock select word, then the two result bytes.
// Refused accesses (outside the four words) raise pslverr, return zero
// and change nothing, so no register is ever aliased by a wider address.
// Result bytes are loaded by a completion pulse or by software; when both
// fall in one cycle the completion wins and the software byte is lost.
// The divider counter is not restarted on a code change, so the first
// converter clock half period after a change may run longer than the new code gives, never shorter.
// The oscillator input is only resampled here; its frequency limit is
// kept by the oscillator that feeds it.
// Result bytes have no reset at all, so a later reset leaves a finished
// result readable.
module adccr_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire dedicated_rc_clock,
	input wire conv_done,
	input wire [9:0] conversion_result,
	output reg conv_clk,
	output reg conv_clk_is_rc
);
	// Software-visible control state
	reg justify_r;
	reg [2:0] clk_sel_r;
	// Result registers, deliberately without reset
	reg [7:0] res_high_r;
	reg [7:0] res_low_r;
	// Divider state
	reg [4:0] div_cnt_r;
	reg div_clk_r;
	// Bus decode
	wire [11:0] addr_w; // Offset within the register page
	wire setup_w; // First cycle of a transfer, no answer standing yet
	wire wr_en; // Write that lands at the end of its access cycle
	wire hit; // Address names one of the four registers
	// Next values of the bus answer
	reg pready_nxt; // Ready for the access cycle
	reg pslverr_nxt; // Error flag beside ready
	reg [31:0] prdata_nxt; // Read word, held until the next read or refused access
	// Next values of the result registers
	reg [7:0] res_high_nxt;
	reg [7:0] res_low_nxt;
	// Next values of the divider
	reg [4:0] div_cnt_nxt;
	reg div_clk_nxt;
	assign addr_w = paddr[11:0];
	// Selected, not yet enabled and no answer standing
	assign setup_w = psel & ~penable & ~pready;
	// An unmapped write is dropped so that no register aliases it
	assign wr_en = psel & penable & pready & pwrite & hit;
	assign hit = (paddr[31:12] == 20'h00000) &&
		((addr_w == `ADCCR_OFF_FORMAT) || (addr_w == `ADCCR_OFF_CTRL2) ||
		(addr_w == `ADCCR_OFF_RES_HIGH) || (addr_w == `ADCCR_OFF_RES_LOW));

	// Half-period count minus one for each divider code
	function [4:0] half_count;
		input [2:0] code;
		begin
			case (code)
				3'h0: half_count = `ADCCR_HALF_DIV2;
				3'h1: half_count = `ADCCR_HALF_DIV8;
				3'h2: half_count = `ADCCR_HALF_DIV32;
				3'h4: half_count = `ADCCR_HALF_DIV4;
				3'h5: half_count = `ADCCR_HALF_DIV16;
				3'h6: half_count = `ADCCR_HALF_DIV64;
				// Codes x11 pick the oscillator; the divider idles at /2
				default: half_count = `ADCCR_HALF_DIV2;
			endcase
		end
	endfunction

	// True when the field selects the internal oscillator
	function rc_selected;
		input [2:0] code;
		begin
			rc_selected = (code[1:0] == 2'h3);
		end
	endfunction

	// APB answer: no wait state, answer stands in the access cycle only
	always @* begin
		pready_nxt = setup_w;
		// Unmapped offsets answer with an error beside ready
		pslverr_nxt = setup_w & ~hit;
		// Read data stands until the next read or refused access
		prdata_nxt = prdata;
		if (setup_w & (~pwrite | ~hit)) begin
			if (!hit) begin
				// A refused access shows zero data, never an aliased register
				prdata_nxt = 32'h00000000;
			end else begin
				// Capture read data in the setup cycle
				case (addr_w)
					`ADCCR_OFF_FORMAT: prdata_nxt = {31'h00000000, justify_r};
					// Bits 7 and 3..0 read zero
					`ADCCR_OFF_CTRL2: prdata_nxt = {25'h0000000, clk_sel_r, 4'h0};
					`ADCCR_OFF_RES_HIGH: prdata_nxt = {24'h000000, res_high_r};
					`ADCCR_OFF_RES_LOW: prdata_nxt = {24'h000000, res_low_r};
					default: prdata_nxt = 32'h00000000;
				endcase
			end
		end
	end

	// Bus answer registers, so every bus output comes from a flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
			prdata <= prdata_nxt;
		end
	end

	// Control registers written by software
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			justify_r <= `ADCCR_FORMAT_RESET;
			clk_sel_r <= `ADCCR_CLKSEL_RESET;
		end else if (wr_en) begin
			// The justify setting applies from the next completion on
			if (addr_w == `ADCCR_OFF_FORMAT) begin
				justify_r <= pwdata[`ADCCR_JUSTIFY_BIT];
			end
			if (addr_w == `ADCCR_OFF_CTRL2) begin
				// Only bits 6..4 are stored
				clk_sel_r <= pwdata[`ADCCR_CLKSEL_HI:`ADCCR_CLKSEL_LO];
			end
		end
	end

	// Result next values: a completion first, then a software write
	always @* begin
		res_high_nxt = res_high_r;
		res_low_nxt = res_low_r;
		if (conv_done) begin
			// Completion wins over a simultaneous software write
			if (justify_r) begin
				// Right layout; reserved high bits are written as zero
				res_high_nxt = {6'h00, conversion_result[9:8]};
				res_low_nxt = conversion_result[7:0];
			end else begin
				// Left layout; reserved low bits are written as zero
				res_high_nxt = conversion_result[9:2];
				res_low_nxt = {conversion_result[1:0], 6'h00};
			end
		end else if (wr_en) begin
			// Software may load either byte directly
			if (addr_w == `ADCCR_OFF_RES_HIGH) begin
				res_high_nxt = pwdata[7:0];
			end
			if (addr_w == `ADCCR_OFF_RES_LOW) begin
				res_low_nxt = pwdata[7:0];
			end
		end
	end

	// Result registers: no reset branch, so they power up unknown and hold
	always @(posedge pclk) begin
		res_high_r <= res_high_nxt;
		res_low_r <= res_low_nxt;
	end

	// Divider next state: wrap at the half-period count of the code
	always @* begin
		div_cnt_nxt = div_cnt_r + 5'h01;
		div_clk_nxt = div_clk_r;
		// The compare is >= so that a smaller code after a change still wraps
		if (div_cnt_r >= half_count(clk_sel_r)) begin
			div_cnt_nxt = 5'h00;
			div_clk_nxt = ~div_clk_r;
		end
	end

	// Bus clock divider, toggles every half period
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_r <= 5'h00;
			div_clk_r <= 1'b0;
		end else begin
			div_cnt_r <= div_cnt_nxt;
			div_clk_r <= div_clk_nxt;
		end
	end

	// Converter clock output and source flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_clk <= 1'b0;
			conv_clk_is_rc <= 1'b0;
		end else begin
			conv_clk_is_rc <= rc_selected(clk_sel_r);
			if (rc_selected(clk_sel_r)) begin
				// Oscillator input passed through one flop
				conv_clk <= dedicated_rc_clock;
			end else begin
				// Divided bus clock
				conv_clk <= div_clk_r;
			end
		end
	end
endmodule

// ---- adccr_defs.vh ----
// Constants for the converter clock select and result format block
`ifndef ADCCR_DEFS_VH
`define ADCCR_DEFS_VH
`define ADCCR_ADDR_W 12
`define ADCCR_OFF_FORMAT 12'h000
`define ADCCR_OFF_CTRL2 12'h004
`define ADCCR_OFF_RES_HIGH 12'h008
`define ADCCR_OFF_RES_LOW 12'h00C
`define ADCCR_JUSTIFY_BIT 0
`define ADCCR_CLKSEL_HI 6
`define ADCCR_CLKSEL_LO 4
`define ADCCR_FORMAT_RESET 1'h0
`define ADCCR_CLKSEL_RESET 3'h0
`define ADCCR_RC_FREQ_MAX_KHZ 500
`define ADCCR_HALF_DIV2 5'h00
`define ADCCR_HALF_DIV4 5'h01
`define ADCCR_HALF_DIV8 5'h03
`define ADCCR_HALF_DIV16 5'h07
`define ADCCR_HALF_DIV32 5'h0F
`define ADCCR_HALF_DIV64 5'h1F
`endif

// ---- adccr_props.sv ----
// Checker for the converter clock select block
`timescale 1ns/1ps
module adccr_props (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire conv_clk_is_rc
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Write that lands in the control register
	wire wr4 = pready && pwrite && paddr == 32'h4;
	// Address is one of the four register words
	wire mapped = paddr[31:4] == 28'h0 && paddr[1:0] == 2'h0;
	a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
	a_err_unmapped: assert property (pready && !mapped |-> pslverr) else $error("no err");
	a_err_mapped: assert property (pready && mapped |-> !pslverr) else $error("bad err");
	a_err_data: assert property (pslverr |-> prdata == 0) else $error("err data");
	a_ctrl_zeros: assert property (pready && !pwrite && paddr == 32'h4
		|-> (prdata & 32'h8F) == 0) else $error("ctrl bits");
	a_rc_select: assert property (wr4 && pwdata[5:4] == 2'b11
		|-> ##[1:2] conv_clk_is_rc) else $error("rc off");
	a_rc_deselect: assert property (wr4 && pwdata[5:4] != 2'b11
		|-> ##[1:2] !conv_clk_is_rc) else $error("rc on");
endmodule
bind adccr_top adccr_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .conv_clk_is_rc);

// ---- tb_top.sv ----
// Testbench for the converter clock select block
`timescale 1ns/1ps
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dedicated_rc_clock = 0;
	logic conv_done = 0, pready, pslverr, conv_clk, conv_clk_is_rc, er, last_clk;
	int toggles, rc_cnt = 0;
	// Converter clock edges in 800 cycles: 1600 / divisor, or 800 / 25 for the oscillator
	int exp_tog [8] = '{800, 200, 50, 32, 400, 100, 25, 32};
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
	logic [9:0] conversion_result = 0;
	int num_errors = 0, check_count = 0;
	// Rows: justify, result, high byte, low byte
	logic [26:0] rows [4] = '{27'h3FFFFC0, 27'h2018040, 27'h7FF03FF, 27'h5550155};
	adccr_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .dedicated_rc_clock, .conv_done, .conversion_result,
		.conv_clk, .conv_clk_is_rc);
	always #20 pclk = ~pclk;
	// Internal oscillator model: toggles every 25 bus clocks, 500 kHz
	always @(posedge pclk) begin
		if (rc_cnt == 24) begin
			rc_cnt <= 0;
			dedicated_rc_clock <= ~dedicated_rc_clock;
		end else begin
			rc_cnt <= rc_cnt + 1;
		end
	end
	// One APB transfer: setup, then access held until pready is sampled high
	task apb(input logic w, input logic [31:0] a, d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			$display("wrong value at %0t: no ready", $time);
		end
		// Answer taken at the edge that sees pready high, then released
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input logic [31:0] g, e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task final_report;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		#1000000;
		num_errors++;
		$display("wrong value at %0t: timeout", $time);
		final_report;
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		foreach (rows[i]) begin
			apb(1, 0, {31'h0, rows[i][26]});
			@(posedge pclk); conv_done <= 1; conversion_result <= rows[i][25:16];
			@(posedge pclk); conv_done <= 0;
			apb(0, 8, 0); chk(rd, {24'h0, rows[i][15:8]});
			apb(0, 12, 0); chk(rd, {24'h0, rows[i][7:0]});
		end
		// A finished result keeps its layout when justify changes later
		apb(1, 0, 0);
		apb(0, 8, 0);
		chk(rd, 32'h1);
		for (int c = 0; c < 8; c++) begin
			apb(1, 4, {24'h0, 1'b1, c[2:0], 4'hF});
			apb(0, 4, 0);
			chk(rd, {24'h0, 1'b0, c[2:0], 4'h0});
			chk(conv_clk_is_rc, {31'h0, c[1:0] == 2'b11});
			// Let the divider settle, then count converter clock edges
			repeat (40) @(posedge pclk);
			@(negedge pclk);
			last_clk = conv_clk;
			toggles = 0;
			repeat (800) begin
				@(negedge pclk);
				if (conv_clk !== last_clk) toggles++;
				last_clk = conv_clk;
			end
			chk(toggles, exp_tog[c]);
		end
		// Unmapped accesses are refused and change nothing
		apb(0, 32'h10, 0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		apb(1, 32'h1000, 32'h1);
		chk(er, 1'b1);
		apb(0, 0, 0);
		chk(rd, 32'h0);
		// Software may load a result byte; results survive a later reset
		apb(1, 8, 32'hA5);
		apb(0, 8, 0);
		chk(rd, 32'hA5);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8, 0);
		chk(rd, 32'hA5);
		apb(0, 12, 0);
		chk(rd, 32'h55);
		apb(0, 4, 0);
		chk(rd, 32'h0);
		chk(conv_clk_is_rc, 32'h0);
		final_report;
	end
endmodule
